// [dv/bridge_model.sv]
// gate driver and switch bridge model seen by the four wave outputs
`timescale 1ns/1ps
module bridge_model (
  // wave outputs of the unit
  input  wire       outA,
  input  wire       outB,
  input  wire       outC,
  input  wire       outD,
  input  wire       outEnA,
  input  wire       outEnB,
  input  wire       outEnC,
  input  wire       outEnD,
  // pin direction chosen by software
  input  wire       pinsOut,
  // levels seen at the gate inputs
  output wire [3:0] pin
);
  // --------------------------------------------------------------
  // pin resolution
  // --------------------------------------------------------------
  // gate inputs carry pull-downs, so an input-held or floated pin reads low
  assign pin = pinsOut ? ({outEnD, outEnC, outEnB, outEnA} & {outD, outC, outB, outA})
                       : 4'h0;
endmodule // bridge_model

// [dv/complementary_wave_unit_chk.sv]
// port-level assertions for the complementary wave unit
`timescale 1ns/1ps
`include "cwu_defines.vh"
module complementary_wave_unit_chk (
  // clock and reset
  input wire                   clk_sys,
  input wire                   arst_n,
  // register port
  input wire [`CWU_ADDR_W-1:0] regAddr,
  input wire [7:0]             regWrData,
  input wire                   regWrStb,
  input wire                   regRdStb,
  input wire [7:0]             regRdData,
  // wave outputs
  input wire                   outEnA,
  input wire                   outEnC,
  // system hooks
  input wire                   waveIrqFlag,
  input wire                   fastOscSelect,
  input wire                   fastOscKeepAwake
);
  // --------------------------------------------------------------
  // mirrors of software-written fields
  // --------------------------------------------------------------
  logic       enQ;
  logic       renQ;
  logic [1:0] acQ;
  wire        wrCtrl0 = regWrStb && regAddr == `CWU_OFS_CTRL0;
  wire        wrTrip  = regWrStb && regAddr == `CWU_OFS_TRIP_CTRL;
  wire        enRise  = wrCtrl0 && !enQ && regWrData[7];
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enQ  <= 1'b0;
      renQ <= 1'b0;
      acQ  <= `CWU_LVL_FLOAT;
    end else begin
      if (wrCtrl0) enQ <= regWrData[7];
      if (wrTrip) renQ <= regWrData[6];
      if (wrTrip) acQ <= regWrData[3:2];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  property p_irqPulse;
    waveIrqFlag |=> !waveIrqFlag;
  endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("irq flag wider than one cycle");
  property p_rdUnmapped;
    regRdStb && (regAddr < `CWU_OFS_CLK_SEL || regAddr > `CWU_OFS_STEER) |=> regRdData == 8'h00;
  endproperty
  a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
  property p_rdHold;
    !regRdStb |=> $stable(regRdData);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved without a read");
  property p_ctrl0Back;
    wrCtrl0 ##2 (regRdStb && regAddr == `CWU_OFS_CTRL0) |=>
      regRdData[7] == $past(regWrData[7], 3) && regRdData[2:0] == $past(regWrData[2:0], 3);
  endproperty
  a_ctrl0Back: assert property (p_ctrl0Back) else $error("enable or mode readback wrong");
  property p_ldRefused;
    enRise && regWrData[6] ##2 (regRdStb && regAddr == `CWU_OFS_CTRL0) |=> !regRdData[6];
  endproperty
  a_ldRefused: assert property (p_ldRefused) else $error("reload set with enable");
  property p_polBack;
    (regWrStb && regAddr == `CWU_OFS_CTRL1) ##2 (regRdStb && regAddr == `CWU_OFS_CTRL1) |=>
      regRdData[3:0] == $past(regWrData[3:0], 3) && regRdData[7:6] == 2'h0 && !regRdData[4];
  endproperty
  a_polBack: assert property (p_polBack) else $error("polarity readback wrong");
  property p_clkSel;
    regWrStb && regAddr == `CWU_OFS_CLK_SEL |=> fastOscSelect == $past(regWrData[0]);
  endproperty
  a_clkSel: assert property (p_clkSel) else $error("clock select not followed");
  property p_awake;
    fastOscKeepAwake |-> fastOscSelect && enQ;
  endproperty
  a_awake: assert property (p_awake) else $error("oscillator held without cause");
  property p_float;
    enRise && acQ == `CWU_LVL_FLOAT ##1 !wrTrip |=> !outEnA && !outEnC;
  endproperty
  a_float: assert property (p_float) else $error("A/C driven after enable");
  property p_shutOnEn;
    enRise && !renQ ##1 !wrTrip ##1 (regRdStb && regAddr == `CWU_OFS_TRIP_CTRL) |=> regRdData[7];
  endproperty
  a_shutOnEn: assert property (p_shutOnEn) else $error("enable did not enter shutdown");
  c_enable: cover property (enRise);
  c_irq: cover property (waveIrqFlag);
  c_awake: cover property (fastOscKeepAwake);
endmodule // complementary_wave_unit_chk
bind complementary_wave_unit complementary_wave_unit_chk i_chk (.clk_sys, .arst_n, .regAddr,
  .regWrData, .regWrStb, .regRdStb, .regRdData, .outEnA, .outEnC, .waveIrqFlag,
  .fastOscSelect, .fastOscKeepAwake);

// [dv/testbench.sv]
// self-checking bench for the complementary wave unit
`timescale 1ns/1ps
`include "cwu_defines.vh"
module testbench;
  logic                   clk_sys, arst_n, regWrStb, regRdStb, pinsOut;
  logic [`CWU_ADDR_W-1:0] regAddr, a;
  logic [7:0]             regWrData, regRdData, dataSrc, rv, wd;
  logic [5:0]             tripSrc;
  logic [3:0]             pin, pol;
  logic                   outA, outB, outC, outD, outEnA, outEnB, outEnC, outEnD;
  logic                   waveIrqFlag, fastOscSelect, fastOscKeepAwake;
  integer                 seed, badCount, totalChecks, irqCount, ic, i;
  complementary_wave_unit i_dut (.clk_sys, .arst_n, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .dataSrc, .tripSrc, .outA, .outB, .outC, .outD, .outEnA, .outEnB,
    .outEnC, .outEnD, .waveIrqFlag, .fastOscSelect, .fastOscKeepAwake);
  bridge_model i_bridge (.outA, .outB, .outC, .outD, .outEnA, .outEnB, .outEnC, .outEnD,
    .pinsOut, .pin);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (waveIrqFlag === 1'b1) irqCount <= irqCount + 1;
  // --------------------------------------------------------------
  // bus and compare helpers
  // --------------------------------------------------------------
  task automatic cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one idle cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    regAddr <= ad;
    regWrData <= d;
    regWrStb <= 1'b1;
    cyc(1);
    regWrStb <= 1'b0;
    cyc(1);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [11:0] ad, input logic [7:0] m, input logic [7:0] exp);
    regAddr <= ad;
    regRdStb <= 1'b1;
    cyc(1);
    regRdStb <= 1'b0;
    cyc(1);
    chk(regRdData & m, exp);
  endtask
  task automatic setData(input logic b);
    rv = $random(seed);
    dataSrc <= {rv[7:1], b};
    cyc(6);
  endtask
  function automatic logic [7:0] keep(input logic [11:0] ad);
    case (ad)
      `CWU_OFS_CLK_SEL: keep = 8'h01;
      `CWU_OFS_IN_SEL, `CWU_OFS_CTRL0: keep = 8'h07;
      `CWU_OFS_CTRL1: keep = 8'h0F;
      `CWU_OFS_TRIP_CTRL: keep = 8'h7C;
      `CWU_OFS_STEER: keep = 8'hFF;
      default: keep = 8'h3F;
    endcase
  endfunction
  // override code to {drive enable, level}
  function automatic logic [1:0] ovr(input logic [1:0] code, input logic p);
    case (code)
      `CWU_LVL_HIGH: ovr = 2'h3;
      `CWU_LVL_LOW: ovr = 2'h2;
      `CWU_LVL_FLOAT: ovr = 2'h0;
      default: ovr = {1'b1, p};
    endcase
  endfunction
  task automatic ovrChk(input logic [1:0] ac, input logic [1:0] bd, input logic [3:0] p);
    logic [7:0] e;
    e = {ovr(bd, p[3]), ovr(ac, p[2]), ovr(bd, p[1]), ovr(ac, p[0])};
    chk({outEnD, outD, outEnC, outC, outEnB, outB, outEnA, outA}, e);
    chk({4'h0, pin}, {4'h0, e[7] & e[6], e[5] & e[4], e[3] & e[2], e[1] & e[0]});
  endtask
  task automatic irqChk(input integer n);
    chk(8'(irqCount - ic), 8'(n));
    ic = irqCount;
  endtask
  task automatic giveVerdict;
    if (badCount == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    seed = 30;
    badCount = 0;
    totalChecks = 0;
    irqCount = 0;
    {arst_n, regWrStb, regRdStb, pinsOut, regAddr, regWrData, dataSrc} = '0;
    tripSrc = `CWU_TRIP_ACT_LOW;
    cyc(8);
    arst_n <= 1'b1;
    cyc(3);
    for (i = 0; i < 11; i++) rdChk(12'hF3A + i, 8'hFF, (i == 7) ? `CWU_RST_TRIP_CTRL : 8'h00);
    for (i = 0; i < 54; i++) begin
      a = 12'hF3B + i % 9;
      rv = $random(seed);
      wd = (a == `CWU_OFS_CTRL0) ? 8'(i / 9) : (a == `CWU_OFS_TRIP_CTRL) ? rv & 8'h7C : rv;
      wr(a, wd);
      rdChk(a, 8'hFF, wd & keep(a));
    end
    wr(`CWU_OFS_IN_SEL, 8'h03);
    dataSrc <= 8'h08;
    cyc(4);
    rdChk(`CWU_OFS_CTRL1, 8'h20, 8'h20);
    wr(`CWU_OFS_IN_SEL, 8'h00);
    setData(1'b0);
    for (i = 0; i < 6; i++) wr(12'hF3D + i, (i == 4) ? 8'h2C : (i == 2) ? 8'h02 : 8'h00);
    ic = irqCount;
    wr(`CWU_OFS_CTRL0, 8'h82);
    rdChk(`CWU_OFS_TRIP_CTRL, 8'h80, 8'h80);
    pinsOut <= 1'b1;
    cyc(3);
    ovrChk(2'h3, 2'h2, 4'h0);
    irqChk(1);
    wr(`CWU_OFS_TRIP_CTRL, 8'h2C);
    rdChk(`CWU_OFS_TRIP_CTRL, 8'h80, 8'h00);
    cyc(10);
    ovrChk(2'h3, 2'h2, 4'h0);
    setData(1'b1);
    chk({outC, outD}, 8'h01);
    wr(`CWU_OFS_TRIP_EN, 8'h02);
    tripSrc[2] <= 1'b1;
    cyc(8);
    irqChk(0);
    tripSrc[1] <= 1'b1;
    cyc(6);
    irqChk(1);
    ovrChk(2'h3, 2'h2, 4'h0);
    wr(`CWU_OFS_TRIP_CTRL, 8'h2C);
    rdChk(`CWU_OFS_TRIP_CTRL, 8'h80, 8'h80);
    cyc(10);
    ovrChk(2'h3, 2'h2, 4'h0);
    wr(`CWU_OFS_TRIP_EN, 8'h00);
    wr(`CWU_OFS_TRIP_CTRL, 8'h2C);
    rdChk(`CWU_OFS_TRIP_CTRL, 8'h80, 8'h00);
    setData(1'b0);
    setData(1'b1);
    chk({outC, outD}, 8'h01);
    tripSrc <= `CWU_TRIP_ACT_LOW;
    wr(`CWU_OFS_TRIP_CTRL, 8'h6C);
    wr(`CWU_OFS_TRIP_EN, 8'h01);
    tripSrc[0] <= 1'b0;
    cyc(6);
    irqChk(1);
    tripSrc[0] <= 1'b1;
    setData(1'b0);
    rdChk(`CWU_OFS_TRIP_CTRL, 8'h80, 8'h00);
    ovrChk(2'h3, 2'h2, 4'h0);
    setData(1'b1);
    chk({outC, outD}, 8'h01);
    wr(`CWU_OFS_TRIP_EN, 8'h00);
    rv = $random(seed);
    pol = rv[3:0];
    wr(`CWU_OFS_CTRL1, {4'h0, pol});
    for (i = 0; i < 4; i++) begin
      wr(`CWU_OFS_TRIP_CTRL, {2'h2, 2'(i), 2'(3 - i), 2'h0});
      cyc(8);
      ovrChk(2'(3 - i), 2'(i), pol);
    end
    irqChk(1);
    wr(`CWU_OFS_TRIP_CTRL, 8'h00);
    setData(1'b0);
    setData(1'b1);
    wr(`CWU_OFS_CTRL0, 8'hC2);
    rdChk(`CWU_OFS_CTRL0, 8'hC7, 8'hC2);
    setData(1'b0);
    rdChk(`CWU_OFS_CTRL0, 8'hC7, 8'hC2);
    setData(1'b1);
    rdChk(`CWU_OFS_CTRL0, 8'hC7, 8'h82);
    wr(`CWU_OFS_TRIP_CTRL, 8'h14);
    wr(`CWU_OFS_CTRL0, 8'h02);
    wr(`CWU_OFS_CTRL0, 8'hC2);
    rdChk(`CWU_OFS_CTRL0, 8'hC7, 8'h82);
    ovrChk(2'h1, 2'h1, pol);
    wr(`CWU_OFS_CLK_SEL, 8'h01);
    chk({7'h0, fastOscSelect}, 8'h01);
    setData(1'b0);
    setData(1'b1);
    chk({7'h0, fastOscKeepAwake}, 8'h01);
    cyc(300);
    chk({7'h0, fastOscKeepAwake}, 8'h00);
    wr(`CWU_OFS_CLK_SEL, 8'h00);
    setData(1'b0);
    chk({6'h0, fastOscSelect, fastOscKeepAwake}, 8'h00);
    giveVerdict;
  end
  // hang guard, far beyond the fewer than eight hundred cycles the scenarios take
  initial begin
    #160000;
    badCount++;
    giveVerdict;
  end
endmodule // testbench

// [rtl/complementary_wave_unit.v]
// control, start-up and fault shutdown logic of the complementary wave unit
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cwu_defines.vh"
//
// Overview of operation
// - entering shutdown, by software or trip, pulses the wave interrupt flag
// - restart waits until every enabled trip source is inactive or disabled
// - without auto-restart software clears shutdown; output resumes at next data rise
// - software clear of shutdown is ignored while an enabled trip is active
// - with auto-restart hardware clears shutdown once trips vanish; resume at data rise
// - keeps running in sleep; fast oscillator held on when enabled, active, selected
// - enabling the unit enters shutdown; override levels must be set beforehand
// - after enable output starts by auto-restart or by software clearing shutdown
// - control zero bit 7 enables the unit, read/write, resets to 0
// - reload request loads gap buffers at rise after first fall, then self-clears
// - reload request cannot be set in the same write that sets enable
// - 3-bit mode selects steering, bridge, half-bridge or push-pull operation
// - control one bit 5 reads the present data input level, writes ignored
// - polarity bits 3:0 invert their output when 1, reset to 0
// - clock select bit 0 picks the fast oscillator when 1, system clock when 0
// - input select bits 2:0 choose one of eight data sources
// - override fields: 11 high, 10 low, 01 float, 00 inactive level after gap
// - trip sources are level sensed; shutdown persists while an enabled one is active
// - six trip source enables gate their sources into the trip logic

module complementary_wave_unit (
  // clock and reset
  input  wire                   clk_sys,
  input  wire                   arst_n,
  // register port
  input  wire [`CWU_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWrStb,
  input  wire                   regRdStb,
  output reg  [7:0]             regRdData,
  // sources from outside this clock domain
  input  wire [7:0]             dataSrc,
  input  wire [5:0]             tripSrc,
  // wave outputs
  output wire                   outA,
  output wire                   outB,
  output wire                   outC,
  output wire                   outD,
  output wire                   outEnA,
  output wire                   outEnB,
  output wire                   outEnC,
  output wire                   outEnD,
  // system hooks
  output reg                    waveIrqFlag,
  output wire                   fastOscSelect,
  output wire                   fastOscKeepAwake
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rstMeta_q;
  reg rstN_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN_q    <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN_q    <= rstMeta_q;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg                 clkSel_q;
  reg [2:0]           dataSel_q;
  reg [`CWU_GAP_W-1:0] riseGap_q;
  reg [`CWU_GAP_W-1:0] fallGap_q;
  reg                 enable_q;
  reg                 reload_q;
  reg [2:0]           mode_q;
  reg [3:0]           invert_q;
  reg                 shutdown_q;
  reg                 autoRestart_q;
  reg [1:0]           bdLevel_q;
  reg [1:0]           acLevel_q;
  reg [5:0]           tripEn_q;
  reg [3:0]           steerEn_q;
  reg [3:0]           steerLvl_q;
  reg [3:0]           steerEnLive_q;
  reg [3:0]           steerLvlLive_q;
  reg [`CWU_GAP_W-1:0] riseBuf_q;
  reg [`CWU_GAP_W-1:0] fallBuf_q;
  reg                 reloadArmed_q;
  reg                 holdOverride_q;
  localparam [7:0]    TRIP_RST = `CWU_RST_TRIP_CTRL;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [7:0] dataMeta_q;
  reg [7:0] dataSync_q;
  reg [5:0] tripMeta_q;
  reg [5:0] tripSync_q;
  reg       dataPrev_q;
  wire      dataIn = dataSync_q[dataSel_q];
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      dataMeta_q <= 8'h00;
      dataSync_q <= 8'h00;
      tripMeta_q <= 6'h00;
      tripSync_q <= 6'h00;
      dataPrev_q <= 1'b0;
    end else begin
      dataMeta_q <= dataSrc;
      dataSync_q <= dataMeta_q;
      tripMeta_q <= tripSrc;
      tripSync_q <= tripMeta_q;
      dataPrev_q <= dataIn;
    end
  end

  wire dataRise = dataIn & ~dataPrev_q;
  wire dataFall = ~dataIn & dataPrev_q;
  // active-low sources are folded to active-high before the enable gate
  wire [5:0] tripLevel = tripSync_q ^ `CWU_TRIP_ACT_LOW;
  wire       tripActive = |(tripLevel & tripEn_q);

  // ------------------------------------------------------------
  // register writes and shutdown state
  // ------------------------------------------------------------
  wire wrCtrl0 = regWrStb && (regAddr == `CWU_OFS_CTRL0);
  wire wrTrip  = regWrStb && (regAddr == `CWU_OFS_TRIP_CTRL);
  wire enRise  = wrCtrl0 && regWrData[`CWU_CTRL0_EN] && !enable_q;
  wire swSetShut = wrTrip && regWrData[`CWU_TRIP_SHUT];
  wire swClrShut = wrTrip && !regWrData[`CWU_TRIP_SHUT] && !tripActive;
  wire hwClrShut = autoRestart_q && !tripActive;
  // any set source wins over a clear in the same cycle
  wire shutSet  = enRise || swSetShut || (tripActive && enable_q);
  wire shutNext = shutSet | (shutdown_q & ~(swClrShut | hwClrShut));
  wire reloadFire = reloadArmed_q && dataRise;

  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      clkSel_q      <= 1'b0;
      dataSel_q     <= 3'h0;
      riseGap_q     <= 6'h00;
      fallGap_q     <= 6'h00;
      enable_q      <= 1'b0;
      reload_q      <= 1'b0;
      mode_q        <= 3'h0;
      invert_q      <= 4'h0;
      shutdown_q    <= 1'b0;
      autoRestart_q <= 1'b0;
      bdLevel_q     <= TRIP_RST[5:4];
      acLevel_q     <= TRIP_RST[3:2];
      tripEn_q      <= 6'h00;
      steerEn_q     <= 4'h0;
      steerLvl_q    <= 4'h0;
      waveIrqFlag   <= 1'b0;
    end else begin
      shutdown_q  <= shutNext;
      waveIrqFlag <= shutNext & ~shutdown_q;
      if (reloadFire) begin
        reload_q <= 1'b0;
      end
      if (regWrStb) begin
        case (regAddr)
          `CWU_OFS_CLK_SEL:  clkSel_q  <= regWrData[0];
          `CWU_OFS_IN_SEL:   dataSel_q <= regWrData[2:0];
          `CWU_OFS_RISE_GAP: riseGap_q <= regWrData[5:0];
          `CWU_OFS_FALL_GAP: fallGap_q <= regWrData[5:0];
          `CWU_OFS_CTRL0: begin
            enable_q <= regWrData[`CWU_CTRL0_EN];
            mode_q   <= regWrData[2:0];
            // set needs enable already on; a pending request survives a 0 write
            if (regWrData[`CWU_CTRL0_LD] && enable_q && regWrData[`CWU_CTRL0_EN]) begin
              reload_q <= 1'b1;
            end
          end
          `CWU_OFS_CTRL1:     invert_q <= regWrData[3:0];
          `CWU_OFS_TRIP_CTRL: begin
            autoRestart_q <= regWrData[`CWU_TRIP_REN];
            bdLevel_q     <= regWrData[5:4];
            acLevel_q     <= regWrData[3:2];
          end
          `CWU_OFS_TRIP_EN: tripEn_q <= regWrData[5:0];
          `CWU_OFS_STEER: begin
            steerLvl_q <= regWrData[7:4];
            steerEn_q  <= regWrData[3:0];
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // gap buffers, reload sequencing, restart hold
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      riseBuf_q      <= 6'h00;
      fallBuf_q      <= 6'h00;
      reloadArmed_q  <= 1'b0;
      holdOverride_q <= 1'b0;
      steerEnLive_q  <= 4'h0;
      steerLvlLive_q <= 4'h0;
    end else begin
      if (!enable_q) begin
        riseBuf_q     <= riseGap_q;
        fallBuf_q     <= fallGap_q;
        reloadArmed_q <= 1'b0;
      end else if (reloadFire) begin
        riseBuf_q     <= riseGap_q;
        fallBuf_q     <= fallGap_q;
        reloadArmed_q <= 1'b0;
      end else if (reload_q && dataFall) begin
        reloadArmed_q <= 1'b1;
      end
      // override stays until the first data rise after shutdown clears
      if (shutdown_q) begin
        holdOverride_q <= 1'b1;
      end else if (dataRise) begin
        holdOverride_q <= 1'b0;
      end
      if (mode_q != `CWU_MODE_STEER_SYNC || dataRise) begin
        steerEnLive_q  <= steerEn_q;
        steerLvlLive_q <= steerLvl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // dead-band timing for half-bridge
  // ------------------------------------------------------------
  reg [`CWU_GAP_W-1:0] riseCnt_q;
  reg [`CWU_GAP_W-1:0] fallCnt_q;
  reg                  riseDone_q;
  reg                  fallDone_q;
  reg                  pushSel_q;
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      riseCnt_q  <= 6'h00;
      fallCnt_q  <= 6'h00;
      riseDone_q <= 1'b0;
      fallDone_q <= 1'b0;
      pushSel_q  <= 1'b0;
    end else begin
      // a pulse shorter than its gap never reaches the output
      if (!dataIn) begin
        riseCnt_q  <= 6'h00;
        riseDone_q <= 1'b0;
      end else if (!riseDone_q) begin
        if (riseCnt_q >= riseBuf_q) riseDone_q <= 1'b1;
        else riseCnt_q <= riseCnt_q + 6'h01;
      end
      if (dataIn) begin
        fallCnt_q  <= 6'h00;
        fallDone_q <= 1'b0;
      end else if (!fallDone_q) begin
        if (fallCnt_q >= fallBuf_q) fallDone_q <= 1'b1;
        else fallCnt_q <= fallCnt_q + 6'h01;
      end
      if (dataRise) begin
        pushSel_q <= ~pushSel_q;
      end
    end
  end

  // ------------------------------------------------------------
  // output mode and override
  // ------------------------------------------------------------
  reg [3:0] waveRaw;
  always @* begin
    waveRaw = 4'h0;
    case (mode_q)
      `CWU_MODE_STEER_ASYNC, `CWU_MODE_STEER_SYNC: begin
        waveRaw = (steerEnLive_q & {4{dataIn}}) | (~steerEnLive_q & steerLvlLive_q);
      end
      `CWU_MODE_FWD_BRIDGE: waveRaw = {dataIn, 1'b0, 1'b0, 1'b1};
      `CWU_MODE_REV_BRIDGE: waveRaw = {1'b0, 1'b1, dataIn, 1'b0};
      `CWU_MODE_HALF_BRIDGE: waveRaw = {fallDone_q, riseDone_q, fallDone_q, riseDone_q};
      `CWU_MODE_PUSH_PULL: begin
        waveRaw = {1'b0, 1'b0, dataIn & ~pushSel_q, dataIn & pushSel_q};
      end
      default: waveRaw = 4'h0;
    endcase
  end

  // steering levels are literal; polarity applies to the waveform only
  wire [3:0] steerMask = (mode_q[2:1] == 2'b00) ? ~steerEnLive_q : 4'h0;
  wire [3:0] waveLive  = waveRaw ^ (invert_q & ~steerMask);
  wire       overrideOn = shutdown_q | holdOverride_q;
  // a gap is still running on the present data level
  wire       gapRun     = dataIn ? ~riseDone_q : ~fallDone_q;

  reg [3:0] outNext;
  reg [3:0] outEnNext;
  reg [1:0] lvl;
  integer   i;
  always @* begin
    outNext   = 4'h0;
    outEnNext = 4'h0;
    lvl       = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      lvl = i[0] ? bdLevel_q : acLevel_q;
      if (overrideOn) begin
        outEnNext[i] = (lvl != `CWU_LVL_FLOAT);
        case (lvl)
          `CWU_LVL_HIGH:     outNext[i] = 1'b1;
          `CWU_LVL_LOW:      outNext[i] = 1'b0;
          `CWU_LVL_FLOAT:    outNext[i] = 1'b0;
          // an active output holds until the running gap ends, then goes inactive
          default: outNext[i] = invert_q[i] ^ (waveRaw[i] & gapRun);
        endcase
      end else if (enable_q) begin
        outEnNext[i] = 1'b1;
        outNext[i]   = waveLive[i];
      end
    end
  end

  reg [3:0] out_q;
  reg [3:0] outEn_q;
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      out_q   <= 4'h0;
      outEn_q <= 4'h0;
    end else begin
      out_q   <= outNext;
      outEn_q <= outEnNext;
    end
  end
  assign outA   = out_q[0];
  assign outB   = out_q[1];
  assign outC   = out_q[2];
  assign outD   = out_q[3];
  assign outEnA = outEn_q[0];
  assign outEnB = outEn_q[1];
  assign outEnC = outEn_q[2];
  assign outEnD = outEn_q[3];

  // ------------------------------------------------------------
  // sleep keep-alive
  // ------------------------------------------------------------
  reg [7:0] idleCnt_q;
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) idleCnt_q <= `CWU_IDLE_WINDOW;
    else if (dataRise | dataFall) idleCnt_q <= 8'h00;
    else if (idleCnt_q != `CWU_IDLE_WINDOW) idleCnt_q <= idleCnt_q + 8'h01;
  end
  assign fastOscSelect    = clkSel_q;
  assign fastOscKeepAwake = enable_q & clkSel_q & (idleCnt_q != `CWU_IDLE_WINDOW);

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rstN_q) begin
    if (!rstN_q) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      case (regAddr)
        `CWU_OFS_CLK_SEL:   regRdData <= {7'h00, clkSel_q};
        `CWU_OFS_IN_SEL:    regRdData <= {5'h00, dataSel_q};
        `CWU_OFS_RISE_GAP:  regRdData <= {2'h0, riseGap_q};
        `CWU_OFS_FALL_GAP:  regRdData <= {2'h0, fallGap_q};
        `CWU_OFS_CTRL0:     regRdData <= {enable_q, reload_q, 3'h0, mode_q};
        `CWU_OFS_CTRL1:     regRdData <= {2'h0, dataIn, 1'b0, invert_q};
        `CWU_OFS_TRIP_CTRL: regRdData <= {shutdown_q, autoRestart_q, bdLevel_q, acLevel_q, 2'h0};
        `CWU_OFS_TRIP_EN:   regRdData <= {2'h0, tripEn_q};
        `CWU_OFS_STEER:     regRdData <= {steerLvl_q, steerEn_q};
        default:            regRdData <= 8'h00;
      endcase
    end
  end

endmodule // complementary_wave_unit

// [shared/cwu_defines.vh]
// register map, field positions and reset values of the complementary wave unit
`ifndef CWU_DEFINES_VH
`define CWU_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CWU_ADDR_W           12
`define CWU_OFS_CLK_SEL      12'hF3B
`define CWU_OFS_IN_SEL       12'hF3C
`define CWU_OFS_RISE_GAP     12'hF3D
`define CWU_OFS_FALL_GAP     12'hF3E
`define CWU_OFS_CTRL0        12'hF3F
`define CWU_OFS_CTRL1        12'hF40
`define CWU_OFS_TRIP_CTRL    12'hF41
`define CWU_OFS_TRIP_EN      12'hF42
`define CWU_OFS_STEER        12'hF43

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CWU_CTRL0_EN         7
`define CWU_CTRL0_LD         6
`define CWU_CTRL1_IN         5
`define CWU_TRIP_SHUT        7
`define CWU_TRIP_REN         6
`define CWU_GAP_W            6

// ------------------------------------------------------------
// mode codes
// ------------------------------------------------------------
`define CWU_MODE_STEER_ASYNC 3'h0
`define CWU_MODE_STEER_SYNC  3'h1
`define CWU_MODE_FWD_BRIDGE  3'h2
`define CWU_MODE_REV_BRIDGE  3'h3
`define CWU_MODE_HALF_BRIDGE 3'h4
`define CWU_MODE_PUSH_PULL   3'h5

// ------------------------------------------------------------
// override level codes
// ------------------------------------------------------------
`define CWU_LVL_HIGH         2'h3
`define CWU_LVL_LOW          2'h2
`define CWU_LVL_FLOAT        2'h1
`define CWU_LVL_INACTIVE     2'h0

// ------------------------------------------------------------
// reset values and trip polarity
// ------------------------------------------------------------
`define CWU_RST_TRIP_CTRL    8'h14
`define CWU_TRIP_ACT_LOW     6'h31
`define CWU_IDLE_WINDOW      8'hFF

`endif
